// *** rtl/sls_pkg.sv ***
package sls_pkg;
  localparam int CLK_MHZ         = 125;
  // times in their own units, cycle counts derived from the clock rate
  localparam int RANGE_DELAY_MS  = 2000;
  localparam int RANGE_DELAY_CYC = RANGE_DELAY_MS * CLK_MHZ * 1000;
  localparam int SETTLE_US       = 10000;
  localparam int SETTLE_CYC      = SETTLE_US * CLK_MHZ;
  localparam int PME_WATCH_US    = 20000;
  localparam int PME_WATCH_CYC   = PME_WATCH_US * CLK_MHZ;
  localparam int K_ASYNC         = 8;
  localparam int K_SYNC          = 4;
  localparam int NIB_STD         = 32;
  localparam int NIB_EXT         = 48;
  localparam int FRAME_W         = 12;
  localparam int FIFO_DEPTH      = 16;
  localparam logic [7:0] BLOCKS_STD = 8'h20;
  localparam logic [7:0] BLOCKS_EXT = 8'h30;
  localparam logic [3:0] RSV_NIB    = 4'h0;
  localparam logic [9:0] ID_BASE    = 10'h200;
  localparam logic [9:0] DATA_BASE  = 10'h210;
  localparam logic [9:0] P0_BASE    = 10'h200;
  localparam logic [9:0] CODE_BUSY  = 10'h1E5;
  localparam logic [9:0] CODE_READY = 10'h1E6;
  localparam logic [9:0] CODE_DEFECT = 10'h1E7;
  localparam logic [9:0] CODE_ERROR = 10'h1E8;
  localparam logic [2:0] STEP_WAIT  = 3'h0;
  localparam logic [2:0] STEP_RDY2  = 3'h2;
  localparam logic [2:0] STEP_P0    = 3'h3;
  localparam logic [2:0] STEP_LAST  = 3'h6;
  typedef enum logic [2:0] {
    PH_SILENT, PH_CONFIG, PH_STATUS, PH_NORMAL, PH_PROG
  } sls_phase_t;
endpackage

// *** rtl/sls_init_seq.sv ***
// Operation
// RULE1 - phase one transmits nothing on the link
// RULE2 - phase two runs self-test, sends configuration
// RULE3 - phase three sends status then reference pressure
// RULE4 - after phase three stay in normal
// RULE5 - asynchronous mode: only source id zero
// RULE6 - synchronous mode: sequence per enabled source id
// RULE7 - daisy chain: frames in source id zero
// RULE8 - hold range error until two-second count
// RULE9 - delay counter cleared at start, never restarted
// RULE10 - after delay, compare and send error
// RULE11 - after init, range error sent immediately
// RULE12 - phase one: settle, filter init, watch entry
// RULE13 - each nibble as id/data pair, k times
// RULE14 - phase two length is product of counts
// RULE15 - 32 nibbles, or 48 when extended
// RULE16 - asynchronous: pair repeated eight times
// RULE17 - synchronous: pair repeated four times
// RULE18 - nibbles two, three give block count
// RULE19 - low nibble first, address wraps at 1111
// RULE20 - two ready messages, latch pressure after second
// RULE21 - pressure in four frames, index plus bits
// RULE22 - self-test retried to limit, stops on pass
// RULE23 - completion flag set leaving phase three
// RULE24 - receiver checks repeated pairs before accepting; sls_rx_model queues every frame and only counts id/data pairs
// RULE25 - encoded phase register only moves forward
module sls_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      if (pop) rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module sls_init_seq #(
  parameter int RANGE_DELAY = sls_pkg::RANGE_DELAY_CYC,
  parameter int SETTLE      = sls_pkg::SETTLE_CYC,
  parameter int PME_WATCH   = sls_pkg::PME_WATCH_CYC,
  parameter int DEPTH       = sls_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // configuration
  input  wire logic        phase2_extend_enable,
  input  wire logic        sync_mode,
  input  wire logic        daisy_mode,
  input  wire logic [3:0]  sid_enable,
  input  wire logic [3:0]  selftest_retry_limit,
  input  wire logic [7:0]  user_byte_zero,
  input  wire logic [63:0] user_bytes_rest,
  input  wire logic [39:0] serial_number,
  input  wire logic [11:0] part_number,
  // pressure and range thresholds
  input  wire logic [11:0] reference_pressure,
  input  wire logic [11:0] range_low,
  input  wire logic [11:0] range_high,
  // programming entry and self-test
  input  wire logic        prog_entry_detect,
  output logic             prog_mode_active,
  output logic             filter_init_start,
  output logic             selftest_start,
  input  wire logic        selftest_done,
  input  wire logic        selftest_pass,
  // frame stream toward the line driver
  output logic             frame_valid,
  input  wire logic        frame_ready,
  output logic [11:0]      frame_data,
  // status
  output logic             init_complete_flag,
  output logic             range_error,
  output logic [2:0]       phase
);
  sls_pkg::sls_phase_t phase_r;
  logic [31:0] tmr_r;
  logic        p1_watch_r;
  logic [5:0]  nib_r;
  logic [3:0]  rep_r;
  logic        half_r;
  logic [1:0]  sid_r;
  logic [2:0]  step_r;
  logic [11:0] p0_lat_r;
  logic        st_run_r, st_pass_r, st_fail_r, st_go_r;
  logic [3:0]  st_tries_r;
  logic [31:0] rdly_r;
  logic        rdly_done_r, err_r, err_pend_r, init_r;
  logic [3:0]  act_mask;
  logic [2:0]  sid_nx;
  logic [3:0]  kmax;
  logic [5:0]  nmax;
  logic        p1_exit, oor, seq_valid, seq_fire, err_push, wrap;
  logic [9:0]  seq_code;
  logic        fifo_in_ready;

  function automatic logic [1:0] sid_first(input logic [3:0] m);
    sid_first = 2'h0;
    for (int j = 3; j >= 0; j--) if (m[j]) sid_first = 2'(j);
  endfunction

  // {wrap, sid}: next enabled id above c, else wrap to the first
  function automatic logic [2:0] sid_next(input logic [1:0] c,
                                          input logic [3:0] m);
    sid_next = {1'b1, sid_first(m)};
    for (int j = 3; j >= 0; j--)
      if (m[j] && j > int'(c)) sid_next = {1'b0, 2'(j)};
  endfunction

  function automatic logic [3:0] nib_val(input logic [5:0] i,
                                         input logic ext);
    logic [7:0] blk;
    logic [71:0] ub;
    blk = ext ? sls_pkg::BLOCKS_EXT : sls_pkg::BLOCKS_STD; // RULE18
    ub  = {user_bytes_rest, user_byte_zero};
    nib_val = sls_pkg::RSV_NIB;
    // user bytes go low nibble first
    case (i) // RULE19
      6'h00:   nib_val = ub[3:0];
      6'h01:   nib_val = blk[7:4];
      6'h02:   nib_val = blk[3:0];
      6'h03, 6'h05, 6'h07, 6'h09, 6'h0B:
               nib_val = ub[8*((int'(i)-1)/2) +: 4];
      6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C:
               nib_val = ub[8*((int'(i)-2)/2)+4 +: 4];
      6'h0D:   nib_val = ub[51:48];
      6'h0E:   nib_val = ub[59:56];
      6'h0F:   nib_val = ub[63:60];
      6'h10:   nib_val = ub[67:64];
      6'h11:   nib_val = ub[71:68];
      6'h1C:   nib_val = part_number[11:8];
      6'h1D:   nib_val = part_number[7:4];
      6'h1E:   nib_val = part_number[3:0];
      6'h1F:   nib_val = ub[55:52];
      default: begin
        if (i >= 6'h12 && i <= 6'h1B)
          nib_val = serial_number[(27-int'(i))*4 +: 4];
      end
    endcase
  endfunction

  // only sync mode with enables and daisy chain off spreads frames over several ids
  assign act_mask = (sync_mode && !daisy_mode && sid_enable != 4'h0) ?
                    sid_enable : 4'h1; // RULE5 RULE6 RULE7
  assign sid_nx   = sid_next(sid_r, act_mask);
  assign wrap     = sid_nx[2];
  assign kmax     = sync_mode ? 4'(sls_pkg::K_SYNC - 1) :
                                4'(sls_pkg::K_ASYNC - 1); // RULE16 RULE17
  assign nmax     = phase2_extend_enable ? 6'(sls_pkg::NIB_EXT - 1) :
                                           6'(sls_pkg::NIB_STD - 1); // RULE15
  assign p1_exit  = phase_r == sls_pkg::PH_SILENT && p1_watch_r &&
                    tmr_r == 32'(PME_WATCH - 1) && !prog_entry_detect;
  assign oor      = reference_pressure < range_low ||
                    reference_pressure > range_high;

  always_comb begin
    seq_valid = 1'b0;
    seq_code  = '0;
    case (phase_r)
      sls_pkg::PH_CONFIG: begin
        seq_valid = 1'b1;
        seq_code  = half_r ? (sls_pkg::DATA_BASE |
                              {6'h00, nib_val(nib_r, phase2_extend_enable)})
                           : (sls_pkg::ID_BASE | {6'h00, nib_r[3:0]}); // RULE13
      end
      sls_pkg::PH_STATUS: begin
        seq_valid = 1'b1;
        if (step_r == sls_pkg::STEP_WAIT) begin
          seq_valid = !(st_pass_r || st_fail_r);
          seq_code  = sls_pkg::CODE_BUSY;
        end else if (step_r < sls_pkg::STEP_P0) begin
          seq_code = st_fail_r ? sls_pkg::CODE_DEFECT : sls_pkg::CODE_READY;
        end else begin
          // two-bit index, then three pressure bits, msb group first
          seq_code = sls_pkg::P0_BASE | {5'h00, 2'(step_r - 3'h3),
                     p0_lat_r[(3'h6 - step_r)*3 +: 3]}; // RULE21
        end
      end
      default: begin
        seq_valid = 1'b0;
        seq_code  = '0;
      end
    endcase
  end

  // the error frame takes the slot, stalling the sequencer one cycle
  assign err_push = err_pend_r && phase_r != sls_pkg::PH_SILENT &&
                    phase_r != sls_pkg::PH_PROG; // RULE1 RULE10
  assign seq_fire = seq_valid && fifo_in_ready && !err_push;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r    <= sls_pkg::PH_SILENT;
      tmr_r      <= '0;
      p1_watch_r <= 1'b0;
      nib_r      <= '0;
      rep_r      <= '0;
      half_r     <= 1'b0;
      sid_r      <= '0;
      step_r     <= '0;
      p0_lat_r   <= '0;
      init_r     <= 1'b0;
    end else begin
      case (phase_r)
        sls_pkg::PH_SILENT: begin // RULE12
          tmr_r <= tmr_r + 32'h1;
          if (!p1_watch_r && tmr_r == 32'(SETTLE - 1)) begin
            p1_watch_r <= 1'b1;
            tmr_r      <= '0;
          end else if (p1_watch_r && prog_entry_detect) begin
            phase_r <= sls_pkg::PH_PROG;
          end else if (p1_exit) begin
            phase_r <= sls_pkg::PH_CONFIG; // RULE25
            sid_r   <= sid_first(act_mask);
          end
        end
        sls_pkg::PH_CONFIG: begin
          // length = 2 frames x k x nibbles x active ids x period // RULE14
          if (seq_fire) begin
            sid_r <= sid_nx[1:0];
            if (wrap) begin
              half_r <= ~half_r;
              if (half_r) begin
                rep_r <= (rep_r == kmax) ? 4'h0 : rep_r + 4'h1;
                if (rep_r == kmax) begin
                  nib_r <= nib_r + 6'h1;
                  if (nib_r == nmax) phase_r <= sls_pkg::PH_STATUS;
                end
              end
            end
          end
        end
        sls_pkg::PH_STATUS: begin // RULE3
          if (step_r == sls_pkg::STEP_WAIT) begin
            if (st_pass_r || st_fail_r) step_r <= 3'h1;
          end else if (seq_fire) begin
            sid_r <= sid_nx[1:0];
            if (wrap) begin
              step_r <= step_r + 3'h1;
              if (step_r == sls_pkg::STEP_RDY2)
                p0_lat_r <= reference_pressure; // RULE20
              if (step_r == sls_pkg::STEP_LAST) begin
                phase_r <= sls_pkg::PH_NORMAL; // RULE4
                init_r  <= 1'b1; // RULE23
              end
            end
          end
        end
        default: phase_r <= phase_r;
      endcase
    end
  end

  // self-test: start on entry to phase two, retry failures to the limit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_run_r   <= 1'b0;
      st_pass_r  <= 1'b0;
      st_fail_r  <= 1'b0;
      st_go_r    <= 1'b0;
      st_tries_r <= '0;
    end else begin
      st_go_r <= 1'b0;
      if (p1_exit) begin
        st_run_r <= 1'b1; // RULE2
        st_go_r  <= 1'b1;
      end else if (st_run_r && selftest_done) begin
        if (selftest_pass) begin
          st_run_r  <= 1'b0; // RULE22
          st_pass_r <= 1'b1;
        end else if (st_tries_r < selftest_retry_limit) begin
          st_tries_r <= st_tries_r + 4'h1;
          st_go_r    <= 1'b1;
        end else begin
          st_run_r  <= 1'b0;
          st_fail_r <= 1'b1;
        end
      end
    end
  end

  // delay counter runs once from reset, blind to the pressure value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdly_r      <= '0; // RULE9
      rdly_done_r <= 1'b0;
      err_r       <= 1'b0;
      err_pend_r  <= 1'b0;
    end else begin
      if (!rdly_done_r) begin
        rdly_r <= rdly_r + 32'h1;
        if (rdly_r == 32'(RANGE_DELAY - 1)) rdly_done_r <= 1'b1;
      end
      err_r <= oor &&
               (rdly_done_r || phase_r == sls_pkg::PH_NORMAL); // RULE8 RULE11
      if (oor && !err_r && (rdly_done_r || phase_r == sls_pkg::PH_NORMAL))
        err_pend_r <= 1'b1; // RULE10
      else if (err_push && fifo_in_ready)
        err_pend_r <= 1'b0;
    end
  end

  sls_fifo #(.WIDTH(sls_pkg::FRAME_W), .DEPTH(DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (err_push | seq_fire),
    .in_ready  (fifo_in_ready),
    .in_data   (err_push ? {2'h0, sls_pkg::CODE_ERROR} : {sid_r, seq_code}),
    .out_valid (frame_valid),
    .out_ready (frame_ready),
    .out_data  (frame_data)
  );

  assign prog_mode_active   = phase_r == sls_pkg::PH_PROG;
  assign filter_init_start  = phase_r == sls_pkg::PH_SILENT && !p1_watch_r &&
                              tmr_r == 32'(SETTLE - 1);
  assign selftest_start     = st_go_r;
  assign init_complete_flag = init_r;
  assign range_error        = err_r;
  assign phase              = phase_r;

  property p_silent;
    @(posedge ref_clk) disable iff (!rst_n)
    phase_r == sls_pkg::PH_SILENT |-> !(err_push || seq_fire);
  endproperty
  a_silent: assert property (p_silent) else $error("silent frame"); // RULE1

  property p_fwd;
    @(posedge ref_clk) disable iff (!rst_n)
    phase_r != $past(phase_r) |-> phase_r > $past(phase_r);
  endproperty
  a_fwd: assert property (p_fwd) else $error("phase went back"); // RULE25

  property p_st_start;
    @(posedge ref_clk) disable iff (!rst_n)
    p1_exit |=> selftest_start && phase_r == sls_pkg::PH_CONFIG;
  endproperty
  a_st_start: assert property (p_st_start) else $error("no selftest"); // RULE2

  property p_krep;
    @(posedge ref_clk) disable iff (!rst_n)
    phase_r == sls_pkg::PH_CONFIG && seq_fire && wrap && half_r &&
    rep_r == (sync_mode ? 4'h3 : 4'h7) |=> rep_r == 4'h0;
  endproperty
  a_krep: assert property (p_krep) else $error("bad repeat"); // RULE16 RULE17

  property p_async_sid;
    @(posedge ref_clk) disable iff (!rst_n)
    seq_fire && !sync_mode |-> sid_r == 2'h0;
  endproperty
  a_async_sid: assert property (p_async_sid) else $error("bad sid"); // RULE5

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    !rdly_done_r && phase_r != sls_pkg::PH_NORMAL |=> !range_error;
  endproperty
  a_hold: assert property (p_hold) else $error("range error early"); // RULE8

  property p_normal_err;
    @(posedge ref_clk) disable iff (!rst_n)
    phase_r == sls_pkg::PH_NORMAL && oor |=> range_error;
  endproperty
  a_normal_err: assert property (p_normal_err) else $error("late"); // RULE11

  property p_flag;
    @(posedge ref_clk) disable iff (!rst_n)
    init_complete_flag == (phase_r == sls_pkg::PH_NORMAL);
  endproperty
  a_flag: assert property (p_flag) else $error("flag mismatch"); // RULE23

  property p_latch;
    @(posedge ref_clk) disable iff (!rst_n)
    phase_r == sls_pkg::PH_STATUS && step_r == sls_pkg::STEP_RDY2 &&
    seq_fire && wrap |=> p0_lat_r == $past(reference_pressure);
  endproperty
  a_latch: assert property (p_latch) else $error("no latch"); // RULE20
endmodule

// *** tb/sls_rx_model.sv ***
module sls_rx_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // frame stream
  input  wire logic        frame_valid,
  output logic             frame_ready,
  input  wire logic [11:0] frame_data,
  // pacing set by the bench
  input  wire logic        slow,
  input  wire logic        hold
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] q[$];
  logic [9:0]  last_id [4];
  logic [1:0]  pace;
  int          pairs;
  initial frame_ready = 1'h0;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.delete();
      pairs = 0;
      pace = 2'h0;
      last_id = '{default: 10'h0};
      frame_ready <= 1'h0;
    end else begin
      if (frame_valid && frame_ready) begin
        q.push_back(frame_data);
        // a data frame counts only after its id frame, per source
        if (frame_data[9:4] == 6'h21 &&
            last_id[frame_data[11:10]][9:4] == 6'h20) begin
          pairs++;
        end
        last_id[frame_data[11:10]] = frame_data[9:0];
      end
      pace = pace + 2'h1;
      // slow mode takes one frame in four
      frame_ready <= #1 !hold && (!slow || pace == 2'h0);
    end
  end
endmodule

// *** tb/test_sls_init_seq.sv ***
module test_sls_init_seq;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic ext, sync, daisy;
    logic [3:0] sid;
    int fail, lim;
    logic slow;
    int k, nib, nsid;
  } sls_row_t;
  localparam logic [63:0] UBR = 64'h0123456789ABCDC3;
  sls_row_t    rows [6];
  logic        ref_clk, rst_n, ext, sync, daisy, prog, slow, hold;
  logic        st_done, st_pass, frame_valid, frame_ready, prog_act;
  logic        filt, st_start, done_f, rerr;
  logic [3:0]  sid, lim;
  logic [7:0]  ub0;
  logic [11:0] p, frame_data;
  logic [11:0] pn, rlo, rhi;
  logic [39:0] sn;
  logic [2:0]  phase, ph_prev;
  int          fail_count, n_tests, cyc, n_start, st_wait, fail_n;
  int          silent, back, early, filt_n, n0;

  sls_init_seq #(.RANGE_DELAY(200), .SETTLE(20), .PME_WATCH(20),
    .DEPTH(16)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .phase2_extend_enable(ext),
    .sync_mode(sync), .daisy_mode(daisy), .sid_enable(sid),
    .selftest_retry_limit(lim), .user_byte_zero(ub0),
    .user_bytes_rest(UBR), .serial_number(sn),
    .part_number(pn), .reference_pressure(p),
    .range_low(rlo), .range_high(rhi),
    .prog_entry_detect(prog), .prog_mode_active(prog_act),
    .filter_init_start(filt), .selftest_start(st_start),
    .selftest_done(st_done), .selftest_pass(st_pass),
    .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame_data(frame_data), .init_complete_flag(done_f),
    .range_error(rerr), .phase(phase));

  sls_rx_model i_rx (.ref_clk(ref_clk), .rst_n(rst_n),
    .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame_data(frame_data), .slow(slow), .hold(hold));

  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  // watchers and a self-test responder that fails the first fail_n runs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {silent, back, early, filt_n, n_start, st_wait} = '0;
      ph_prev = 3'h0;
      st_done <= 1'h0;
      st_pass <= 1'h0;
    end else begin
      if (frame_valid && frame_ready && phase == 3'h0) silent++;
      if (phase < ph_prev) back++;
      ph_prev = phase;
      if (done_f && phase != 3'h3) early++;
      if (filt) filt_n++;
      st_done <= 1'h0;
      if (st_wait == 1) begin
        st_done <= 1'h1;
        st_pass <= n_start > fail_n;
      end
      if (st_wait > 0) st_wait--;
      if (st_start) begin
        n_start++;
        st_wait = 5;
      end
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic do_reset;
    rst_n = 1'h0;
    tick(10);
    rst_n = 1'h1;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (!(done_f === 1'h1 && frame_valid === 1'h0) && n < 9000) begin
      tick(1);
      n++;
    end
    check(n < 9000, 1);
    tick(4);
  endtask

  function automatic logic [3:0] nib_val(input int i);
    case (i)
      0: return ub0[3:0];
      1: return ext ? 4'h3 : 4'h2;
      2: return 4'h0;
      3: return UBR[3:0];
      28: return pn[11:8];
      29: return pn[7:4];
      30: return pn[3:0];
      default: return UBR[7:4];
    endcase
  endfunction

  task automatic run_row(input int r);
    int k, nb, ns, base, j;
    logic [1:0] sd;
    logic [9:0] rc;
    logic [11:0] ex;
    k = rows[r].k;
    nb = rows[r].nib;
    ns = rows[r].nsid;
    {ext, sync, daisy, sid, slow} = {rows[r].ext, rows[r].sync,
      rows[r].daisy, rows[r].sid, rows[r].slow};
    fail_n = rows[r].fail;
    lim = rows[r].lim[3:0];
    do_reset();
    wait_done();
    check(silent, 0);
    check(back, 0);
    check(early, 0);
    check(done_f, 1'h1);
    check(phase, 3'h3);
    check(filt_n, 1);
    j = fail_n > rows[r].lim ? rows[r].lim : fail_n;
    check(n_start, j + 1);
    check(i_rx.pairs >= k * nb * ns, 1);
    check(i_rx.q.size() >= 2 * k * nb * ns + 6, 1);
    for (int i = 0; i < nb; i++) begin
      for (int rr = 0; rr < k; rr++) begin
        for (int t = 0; t < ns; t++) begin
          base = (i * k + rr) * 2 * ns;
          // second enabled source of the 0101 mask is number 2
          sd = t ? 2'h2 : 2'h0;
          ex = {sd, sls_pkg::ID_BASE | 10'(i[3:0])};
          check(i_rx.q[base+t], ex);
          if (i < 5 || (i > 27 && i < 31)) begin
            ex = {sd, sls_pkg::DATA_BASE | 10'(nib_val(i))};
            check(i_rx.q[base+ns+t], ex);
          end else begin
            check(i_rx.q[base+ns+t][11:4], {sd, 6'h21});
          end
        end
      end
    end
    if (ns == 1) begin
      j = 2 * k * nb;
      while (j < i_rx.q.size() &&
             i_rx.q[j] === {2'h0, sls_pkg::CODE_BUSY}) j++;
      rc = fail_n <= rows[r].lim ? sls_pkg::CODE_READY : sls_pkg::CODE_DEFECT;
      check(i_rx.q[j], {2'h0, rc});
      check(i_rx.q[j+1], {2'h0, rc});
      for (int x = 0; x < 4; x++) begin
        ex = {2'h0, sls_pkg::P0_BASE | {5'h0, 2'(x), p[11-3*x -: 3]}};
        check(i_rx.q[j+2+x], ex);
      end
    end
    $display("row %0d done", r);
  endtask

  initial begin
    {rst_n, ext, sync, daisy, prog, slow, hold} = 7'h0;
    {sid, lim, ub0, p} = {4'h1, 4'h0, 8'h5A, 12'h9B7};
    {sn, pn, rlo, rhi} = {40'h13579BDF02, 12'h5A6, 12'h100, 12'hE00};
    {fail_count, n_tests, fail_n} = '0;
    rows = '{
      '{1'h0, 1'h0, 1'h0, 4'hF, 0, 2, 1'h0, 8, 32, 1},
      '{1'h1, 1'h0, 1'h0, 4'hF, 1, 2, 1'h1, 8, 48, 1},
      '{1'h0, 1'h1, 1'h0, 4'h1, 0, 0, 1'h0, 4, 32, 1},
      '{1'h0, 1'h1, 1'h0, 4'h5, 0, 0, 1'h0, 4, 32, 2},
      '{1'h0, 1'h1, 1'h1, 4'h5, 3, 1, 1'h0, 4, 32, 1},
      '{1'h1, 1'h1, 1'h0, 4'h1, 0, 0, 1'h1, 4, 48, 1}
    };
    for (int r = 0; r < 6; r++) run_row(r);
    // in normal mode a range fault is flagged and sent at once
    p = 12'hF00;
    tick(2);
    check(rerr, 1'h1);
    tick(12);
    check(i_rx.q[$], {2'h0, sls_pkg::CODE_ERROR});
    check(phase, 3'h3);
    // a low threshold raised above the pressure flags it as well
    p = 12'h800;
    tick(2);
    check(rerr, 1'h0);
    n0 = i_rx.q.size();
    rlo = 12'h900;
    tick(2);
    check(rerr, 1'h1);
    tick(12);
    check(i_rx.q.size(), n0 + 1);
    check(i_rx.q[$], {2'h0, sls_pkg::CODE_ERROR});
    {rlo, p} = {12'h100, 12'hF00};
    $display("normal range test done");
    // delay count runs 200 cycles from reset whatever the pressure does
    {ext, sync, daisy, slow} = 4'h0;
    do_reset();
    tick(100);
    p = 12'h800;
    tick(50);
    p = 12'hF00;
    tick(40);
    check(rerr, 1'h0);
    tick(25);
    check(rerr, 1'h1);
    // stall the receiver so the buffer fills and the sequencer waits
    hold = 1'h1;
    tick(60);
    check(frame_valid, 1'h1);
    check(phase, 3'h1);
    hold = 1'h0;
    wait_done();
    check(frame_valid, 1'h0);
    check(sls_pkg::CODE_ERROR inside {i_rx.q}, 1'h1);
    rst_n = 1'h0;
    tick(2);
    check({phase, frame_valid, done_f, rerr}, 6'h0);
    $display("range delay test done");
    // programming entry seen in the watch window ends in program mode
    prog = 1'h1;
    p = 12'h800;
    do_reset();
    tick(80);
    check(phase, sls_pkg::PH_PROG);
    check(prog_act, 1'h1);
    check(i_rx.q.size(), 0);
    prog = 1'h0;
    $display("program entry test done");
    finish_test();
  end
endmodule
